// ---- logic/wakeup_timer_pkg.sv ----
// package: constants, register map and divider table of the wake-up timer
package wakeup_timer_pkg;

    // ------------------------------------------------------------------
    // clocking
    // ------------------------------------------------------------------
    localparam int unsigned CLK_FREQ_HZ = 25_000_000;
    localparam int unsigned CLK_PERIOD_NS = 40;
    localparam int unsigned OSC_FREQ_HZ = 10_000;
    // system clock cycles per low-power oscillator period
    localparam int unsigned OSC_TICK_CYCLES = CLK_FREQ_HZ / OSC_FREQ_HZ;

    // ------------------------------------------------------------------
    // widths
    // ------------------------------------------------------------------
    localparam int OSC_CNT_W = 12;
    localparam int PRE_CNT_W = 10;
    localparam int CNT_W = 6;
    localparam int SEL_W = 3;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int CTRL_W = 8;

    // ------------------------------------------------------------------
    // counter limits: a time-out after 64 prescaled periods
    // ------------------------------------------------------------------
    localparam logic [CNT_W-1:0] CNT_ZERO = 6'h00;
    localparam logic [CNT_W-1:0] CNT_LAST = 6'h3f;
    localparam logic [PRE_CNT_W-1:0] PRE_ZERO = 10'h000;
    localparam logic [OSC_CNT_W-1:0] OSC_ZERO = 12'h000;

    // ------------------------------------------------------------------
    // register map (control register index is printed, byte address is 4x)
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] CTRL_INDEX = 12'h0ab;
    localparam logic [ADDR_W-1:0] CTRL_ADDR = {CTRL_INDEX[ADDR_W-3:0], 2'b00};
    localparam logic [ADDR_W-1:0] EXT_IRQ_EN_ADDR = 12'h300;
    localparam logic [ADDR_W-1:0] GLOBAL_IRQ_ADDR = 12'h304;
    localparam logic [ADDR_W-1:0] IRQ_STATUS_ADDR = 12'h308;
    localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR = 12'h30c;
    localparam logic [ADDR_W-1:0] COUNT_ADDR = 12'h310;

    // ------------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------------
    localparam int CTRL_RUN_BIT = 7;
    localparam int CTRL_CLR_BIT = 6;
    localparam int CTRL_FLAG_BIT = 5;
    localparam int CTRL_RSV_HI = 4;
    localparam int CTRL_RSV_LO = 3;
    localparam int CTRL_SEL_LSB = 0;
    localparam int EXT_IRQ_WAKE_BIT = 1;
    localparam int GLOBAL_IRQ_BIT = 0;
    localparam int STAT_TIMEOUT_BIT = 0;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 8'h00;
    localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

    // ------------------------------------------------------------------
    // last prescaler count per interval select code
    // ------------------------------------------------------------------
    function automatic logic [PRE_CNT_W-1:0] div_last(input logic [SEL_W-1:0] sel);
        logic [PRE_CNT_W-1:0] last;
        case (sel)
            3'h0: last = 10'h000;
            3'h1: last = 10'h003;
            3'h2: last = 10'h007;
            3'h3: last = 10'h01f;
            3'h4: last = 10'h03f;
            3'h5: last = 10'h0ff;
            3'h6: last = 10'h1ff;
            default: last = 10'h3ff;
        endcase
        return last;
    endfunction : div_last

endpackage : wakeup_timer_pkg

// ---- logic/wakeup_prescaler.sv ----
// module: selectable prescaler between the oscillator tick and the wake-up counter
`timescale 1ns/1ps
module wakeup_prescaler
    import wakeup_timer_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // control
    input wire logic osc_tick,
    input wire logic run,
    input wire logic restart,
    input wire logic [SEL_W-1:0] sel,
    // output
    output logic prescaled_tick
);

    typedef struct packed {
        logic [PRE_CNT_W-1:0] cnt;
    } pre_state_t;

    pre_state_t st;
    pre_state_t next_st;
    logic [PRE_CNT_W-1:0] last;

    // ------------------------------------------------------------------
    // divider
    // ------------------------------------------------------------------
    assign last = div_last(sel);
    assign prescaled_tick = run && osc_tick && !restart && (st.cnt >= last);

    always_comb begin
        next_st = st;
        if (restart) begin
            next_st.cnt = PRE_ZERO;
        end else if (run && osc_tick) begin
            // >= keeps a shrinking select from running the count past its end
            if (st.cnt >= last) begin
                next_st.cnt = PRE_ZERO;
            end else begin
                next_st.cnt = PRE_CNT_W'(st.cnt + 1'b1);
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    property p_div_one;
        run && osc_tick && !restart && sel == 3'h0 |-> prescaled_tick;
    endproperty
    a_div_one: assert property (p_div_one) else $error("divide by one missed a tick");

    property p_div_four;
        prescaled_tick && sel == 3'h1 |=> st.cnt == PRE_ZERO;
    endproperty
    a_div_four: assert property (p_div_four) else $error("prescaler did not wrap");

endmodule : wakeup_prescaler

// ---- logic/low_power_wakeup_timer.sv ----
// module: low-power wake-up timer with APB register access
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
module low_power_wakeup_timer
    import wakeup_timer_pkg::*;
#(
    parameter int unsigned OSC_CYCLES = OSC_TICK_CYCLES
)
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // to cpu core and power control
    output logic wakeup_irq_req,
    output logic wakeup_pulse,
    // system interrupt
    output logic irq
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [OSC_CNT_W-1:0] osc_cnt;
        logic wakeup_run_enable;
        logic wakeup_timeout_flag;
        logic [SEL_W-1:0] interval_select;
        logic [CNT_W-1:0] wakeup_counter;
        logic wakeup_irq_enable;
        logic global_irq_enable;
        logic irq_status;
        logic irq_mask;
        logic [DATA_W-1:0] rdata;
        logic wake;
    } timer_state_t;

    localparam logic [OSC_CNT_W-1:0] OSC_LAST = OSC_CNT_W'(OSC_CYCLES - 1);

    timer_state_t st;
    timer_state_t next_st;

    logic osc_tick;
    logic prescaled_tick;
    logic setup_rd;
    logic access;
    logic wr_acc;
    logic rd_acc;
    logic mapped;
    logic ctrl_wr;
    logic count_clear;
    logic timeout;
    logic [CTRL_W-1:0] ctrl_view;

    // ------------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------------
    assign setup_rd = psel && !penable && !pwrite;
    assign access = psel && penable;
    assign wr_acc = access && pwrite;
    assign rd_acc = access && !pwrite;
    assign ctrl_wr = wr_acc && (paddr == CTRL_ADDR);
    assign count_clear = ctrl_wr && pwdata[CTRL_CLR_BIT];

    always_comb begin
        case (paddr)
            CTRL_ADDR: mapped = 1'b1;
            EXT_IRQ_EN_ADDR: mapped = 1'b1;
            GLOBAL_IRQ_ADDR: mapped = 1'b1;
            IRQ_STATUS_ADDR: mapped = 1'b1;
            IRQ_MASK_ADDR: mapped = 1'b1;
            COUNT_ADDR: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // zero wait states: read data is captured in the setup cycle
    assign pready = 1'b1;
    assign pslverr = access && !mapped;
    assign prdata = st.rdata;

    // ------------------------------------------------------------------
    // oscillator tick and prescaler
    // ------------------------------------------------------------------
    // no sleep input exists, so idle or power down cannot stall the count
    assign osc_tick = (st.osc_cnt == OSC_LAST);

    wakeup_prescaler u_prescaler (
        .clk_sys(clk_sys),
        .srst(srst),
        .osc_tick(osc_tick),
        .run(st.wakeup_run_enable),
        .restart(count_clear),
        .sel(st.interval_select),
        .prescaled_tick(prescaled_tick)
    );

    // 64 prescaled periods per time-out
    assign timeout = prescaled_tick && (st.wakeup_counter == CNT_LAST);

    // reserved and write-only bits always read back as zero
    always_comb begin
        ctrl_view = CTRL_RESET;
        ctrl_view[CTRL_RUN_BIT] = st.wakeup_run_enable;
        ctrl_view[CTRL_FLAG_BIT] = st.wakeup_timeout_flag;
        ctrl_view[CTRL_SEL_LSB +: SEL_W] = st.interval_select;
    end

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.wake = 1'b0;
        // oscillator runs regardless of the run enable
        if (osc_tick) begin
            next_st.osc_cnt = OSC_ZERO;
        end else begin
            next_st.osc_cnt = OSC_CNT_W'(st.osc_cnt + 1'b1);
        end
        // counter
        if (count_clear) begin
            next_st.wakeup_counter = CNT_ZERO;
        end else if (prescaled_tick) begin
            if (timeout) begin
                next_st.wakeup_counter = CNT_ZERO;
            end else begin
                next_st.wakeup_counter = CNT_W'(st.wakeup_counter + 1'b1);
            end
        end
        // register writes
        if (ctrl_wr) begin
            next_st.wakeup_run_enable = pwdata[CTRL_RUN_BIT];
            next_st.interval_select = pwdata[CTRL_SEL_LSB +: SEL_W];
            if (!pwdata[CTRL_FLAG_BIT]) begin
                next_st.wakeup_timeout_flag = 1'b0;
            end
        end
        if (wr_acc && paddr == EXT_IRQ_EN_ADDR) begin
            next_st.wakeup_irq_enable = pwdata[EXT_IRQ_WAKE_BIT];
        end
        if (wr_acc && paddr == GLOBAL_IRQ_ADDR) begin
            next_st.global_irq_enable = pwdata[GLOBAL_IRQ_BIT];
        end
        if (wr_acc && paddr == IRQ_MASK_ADDR) begin
            next_st.irq_mask = pwdata[STAT_TIMEOUT_BIT];
        end
        // status clears on the completing read
        if (rd_acc && paddr == IRQ_STATUS_ADDR) begin
            next_st.irq_status = 1'b0;
        end
        // a time-out in the clearing cycle still sets: set wins
        if (timeout) begin
            next_st.wakeup_timeout_flag = 1'b1;
            next_st.irq_status = 1'b1;
            next_st.wake = 1'b1;
        end
        // read data
        next_st.rdata = DATA_ZERO;
        if (setup_rd) begin
            case (paddr)
                CTRL_ADDR: next_st.rdata[CTRL_W-1:0] = ctrl_view;
                EXT_IRQ_EN_ADDR: next_st.rdata[EXT_IRQ_WAKE_BIT] = st.wakeup_irq_enable;
                GLOBAL_IRQ_ADDR: next_st.rdata[GLOBAL_IRQ_BIT] = st.global_irq_enable;
                // report a time-out of the setup cycle too, so the read-clear loses none
                IRQ_STATUS_ADDR: next_st.rdata[STAT_TIMEOUT_BIT] = next_st.irq_status;
                IRQ_MASK_ADDR: next_st.rdata[STAT_TIMEOUT_BIT] = st.irq_mask;
                COUNT_ADDR: next_st.rdata[CNT_W-1:0] = st.wakeup_counter;
                default: next_st.rdata = DATA_ZERO;
            endcase
        end
    end

    // every field, control register included, resets to zero
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign wakeup_irq_req = st.wakeup_timeout_flag && st.wakeup_irq_enable
        && st.global_irq_enable;
    assign wakeup_pulse = st.wake;
    assign irq = st.irq_status && st.irq_mask;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    sequence s_overflow;
        prescaled_tick && st.wakeup_counter == CNT_LAST;
    endsequence

    sequence s_ctrl_read;
        setup_rd && paddr == CTRL_ADDR ##1 access && !pwrite;
    endsequence

    sequence s_status_read;
        setup_rd && paddr == IRQ_STATUS_ADDR ##1 rd_acc && !timeout;
    endsequence

    property p_wake;
        s_overflow |=> wakeup_pulse ##1 !wakeup_pulse;
    endproperty
    a_wake: assert property (p_wake) else $error("time-out gave no wake pulse");

    property p_wake_cause;
        wakeup_pulse |-> $past(timeout);
    endproperty
    a_wake_cause: assert property (p_wake_cause) else $error("wake pulse without time-out");

    property p_osc;
        osc_tick |=> st.osc_cnt == OSC_ZERO && !osc_tick;
    endproperty
    a_osc: assert property (p_osc) else $error("oscillator tick did not restart");

    property p_stop;
        !st.wakeup_run_enable && !count_clear |=> $stable(st.wakeup_counter);
    endproperty
    a_stop: assert property (p_stop) else $error("counter moved while stopped");

    property p_clear;
        count_clear |=> st.wakeup_counter == CNT_ZERO;
    endproperty
    a_clear: assert property (p_clear) else $error("clear did not zero the counter");

    property p_ctrl_read;
        s_ctrl_read |-> !prdata[CTRL_CLR_BIT] && prdata[CTRL_RSV_HI:CTRL_RSV_LO] == 2'b00
            && prdata[CTRL_RUN_BIT] == st.wakeup_run_enable;
    endproperty
    a_ctrl_read: assert property (p_ctrl_read) else $error("control read-back wrong");

    property p_flag_set;
        s_overflow |=> st.wakeup_timeout_flag && st.irq_status;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("overflow did not set the flag");

    property p_flag_hold;
        st.wakeup_timeout_flag && !(ctrl_wr && !pwdata[CTRL_FLAG_BIT])
            |=> st.wakeup_timeout_flag;
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag dropped on its own");

    property p_wrap;
        s_overflow ##0 !count_clear |=> st.wakeup_counter == CNT_ZERO;
    endproperty
    a_wrap: assert property (p_wrap) else $error("counter did not wrap");

    property p_irq_req;
        s_overflow |=> wakeup_irq_req == (st.wakeup_irq_enable && st.global_irq_enable);
    endproperty
    a_irq_req: assert property (p_irq_req) else $error("enabled time-out gave no request");

    property p_irq_gate;
        !st.global_irq_enable || !st.wakeup_irq_enable |-> !wakeup_irq_req;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("request with an enable low");

    property p_irq_enable_bit;
        wr_acc && paddr == EXT_IRQ_EN_ADDR |=> st.wakeup_irq_enable == $past(pwdata[1]);
    endproperty
    a_irq_enable_bit: assert property (p_irq_enable_bit) else $error("enable bit misplaced");

    property p_reset;
        $fell(srst) |-> !st.wakeup_run_enable && !st.wakeup_timeout_flag
            && st.interval_select == 3'h0 && !wakeup_irq_req;
    endproperty
    a_reset: assert property (p_reset) else $error("control not zero after reset");

    property p_status_clear;
        s_status_read |=> !irq;
    endproperty
    a_status_clear: assert property (p_status_clear) else $error("status read did not clear");

    property p_ready;
        access |-> pready;
    endproperty
    a_ready: assert property (p_ready) else $error("access phase stretched");

    property p_prdata_idle;
        !access |-> prdata == DATA_ZERO;
    endproperty
    a_prdata_idle: assert property (p_prdata_idle) else $error("read data outside access");

    property p_run_write;
        ctrl_wr |=> st.wakeup_run_enable == $past(pwdata[CTRL_RUN_BIT]);
    endproperty
    a_run_write: assert property (p_run_write) else $error("run enable not written");

    property p_select_write;
        ctrl_wr |=> st.interval_select == $past(pwdata[CTRL_SEL_LSB +: SEL_W]);
    endproperty
    a_select_write: assert property (p_select_write) else $error("select not written");

    property p_stopped;
        !st.wakeup_run_enable |-> !prescaled_tick;
    endproperty
    a_stopped: assert property (p_stopped) else $error("tick while stopped");

    sequence s_step;
        prescaled_tick && !timeout && !count_clear;
    endsequence

    property p_step;
        s_step |=> st.wakeup_counter == $past(st.wakeup_counter) + 1'b1;
    endproperty
    a_step: assert property (p_step) else $error("counter missed a step");

    property p_status_hold;
        st.irq_status && !(rd_acc && paddr == IRQ_STATUS_ADDR) |=> st.irq_status;
    endproperty
    a_status_hold: assert property (p_status_hold) else $error("status dropped on its own");

    property p_irq_set;
        s_overflow |=> irq == st.irq_mask;
    endproperty
    a_irq_set: assert property (p_irq_set) else $error("time-out did not reach irq");

endmodule : low_power_wakeup_timer

// ---- dv/cpu_irq_model.sv ----
// partner model: cpu core that sleeps on command and wakes on the timer pulse
`timescale 1ns/1ps
module cpu_irq_model (
    // clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // timer side and bench side
    input wire logic wakeup_pulse,
    input wire logic go_sleep,
    output logic asleep
);
    // ------------
    // sleep state
    // ------------
    // the model keeps running on clk_sys while asleep; only the timer pulse or srst can end it
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            asleep <= 1'b0;
        end else if (wakeup_pulse) begin
            asleep <= 1'b0;
        end else if (go_sleep) begin
            asleep <= 1'b1;
        end
    end
endmodule : cpu_irq_model

// ---- dv/low_power_wakeup_timer_tb_top.sv ----
// self-checking bench of the low-power wake-up timer
`timescale 1ns/1ps
module low_power_wakeup_timer_tb_top;
    import wakeup_timer_pkg::*;
    // ------------
    // signals
    // ------------
    // short oscillator period keeps the slowest divider within the run budget
    localparam int unsigned OSC = 4;
    localparam int LIMIT = 40000;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = 12'h000;
    logic [DATA_W-1:0] pwdata = 32'h0000_0000;
    logic [DATA_W-1:0] prdata;
    logic pready, pslverr, wakeup_irq_req, wakeup_pulse, irq;
    logic go_sleep = 1'b0;
    logic asleep, slept, err;
    logic [31:0] seed = 32'h7b32_a8ec;
    logic [DATA_W-1:0] rd, d, cnt;
    logic [ADDR_W-1:0] regs [6] = '{CTRL_ADDR, EXT_IRQ_EN_ADDR, GLOBAL_IRQ_ADDR,
        IRQ_STATUS_ADDR, IRQ_MASK_ADDR, COUNT_ADDR};
    int fail_count = 0;
    int tests_run = 0;
    int cycles = 0;
    int n;

    low_power_wakeup_timer #(.OSC_CYCLES(OSC)) dut (.clk_sys(clk_sys), .srst(srst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .wakeup_irq_req(wakeup_irq_req), .wakeup_pulse(wakeup_pulse), .irq(irq));
    cpu_irq_model cpu (.clk_sys(clk_sys), .srst(srst), .wakeup_pulse(wakeup_pulse),
        .go_sleep(go_sleep), .asleep(asleep));

    always #20 clk_sys = ~clk_sys;

    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            $display("ERROR %0t run did not finish", $time);
            fail_count++;
            complete_run();
        end
    end

    // ------------
    // helpers
    // ------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs

    function automatic int div_of(input int s);
        int t [8] = '{1, 4, 8, 32, 64, 256, 512, 1024};
        return t[s];
    endfunction : div_of

    // clear bit never reads back, flag is kept by writing 1 and cleared by writing 0, reserved bits read 0
    function automatic logic [DATA_W-1:0] exp_ctrl(input logic [DATA_W-1:0] w,
        input logic flag);
        return {24'h00_0000, w[7], 1'b0, flag & w[5], 2'b00, w[2:0]};
    endfunction : exp_ctrl

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : complete_run

    task automatic check_val(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t value %h expected %h", $time, got, exp);
        end
    endtask : check_val

    task automatic check_bit(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t flag %b expected %b", $time, got, exp);
        end
    endtask : check_bit

    task automatic check_range(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] lo,
        input logic [DATA_W-1:0] hi);
        tests_run++;
        if ($isunknown(got) || got < lo || got > hi) begin
            fail_count++;
            $display("ERROR %0t count %0d outside %0d..%0d", $time, got, lo, hi);
        end
    endtask : check_range

    // one apb transfer; answer and read data are taken at the completing edge
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
        input logic [DATA_W-1:0] w);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= w;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // idle edge: the next setup never drives psel twice in one step
        @(posedge clk_sys);
    endtask : apb

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] w);
        apb(1'b1, a, w);
    endtask : wr

    task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        apb(1'b0, a, DATA_ZERO);
        check_val(rd, exp);
    endtask : rdchk

    task automatic wait_pulse();
        n = 0;
        do begin
            @(negedge clk_sys);
            n++;
        end while (wakeup_pulse !== 1'b1);
        slept = asleep;
        @(posedge clk_sys);
    endtask : wait_pulse

    task automatic do_reset();
        srst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        srst <= 1'b0;
    endtask : do_reset

    task automatic timeout_case(input logic ext, input logic glob, input logic msk);
        wr(EXT_IRQ_EN_ADDR, {30'h0000_0000, ext, 1'b0});
        wr(GLOBAL_IRQ_ADDR, {31'h0000_0000, glob});
        wr(IRQ_MASK_ADDR, {31'h0000_0000, msk});
        wr(CTRL_ADDR, 32'h0000_0080);
        apb(1'b0, IRQ_STATUS_ADDR, DATA_ZERO);
        go_sleep <= 1'b1;
        @(posedge clk_sys);
        go_sleep <= 1'b0;
        wait_pulse();
        check_bit(slept, 1'b1);
        check_bit(wakeup_irq_req, ext & glob);
        check_bit(irq, msk);
        rdchk(CTRL_ADDR, 32'h0000_00a0);
        check_bit(asleep, 1'b0);
        rdchk(IRQ_STATUS_ADDR, 32'h0000_0001);
        @(negedge clk_sys);
        check_bit(irq, 1'b0);
        @(posedge clk_sys);
    endtask : timeout_case

    // ------------
    // main sequence
    // ------------
    initial begin
        do_reset();
        foreach (regs[i]) begin
            rdchk(regs[i], DATA_ZERO);
            check_bit(err, 1'b0);
        end
        rdchk(12'h314, DATA_ZERO);
        check_bit(err, 1'b1);
        wr(12'h318, 32'hffff_ffff);
        check_bit(err, 1'b1);
        wr(CTRL_ADDR, 32'h0000_0040);
        wr(CTRL_ADDR, 32'h0000_0080);
        timeout_case(1'b1, 1'b1, 1'b1);
        // first wait aligns to a pulse, second measures one full period
        wait_pulse();
        wait_pulse();
        check_range(32'(n), 32'(64 * OSC), 32'(64 * OSC));
        timeout_case(1'b1, 1'b0, 1'b1);
        timeout_case(1'b0, 1'b1, 1'b0);
        wr(CTRL_ADDR, 32'h0000_0020);
        apb(1'b0, COUNT_ADDR, DATA_ZERO);
        cnt = rd;
        for (int k = 0; k < 8; k++) begin
            seed = xs(seed);
            d = (seed & 32'hffff_ff7f) | 32'h0000_0020;
            wr(CTRL_ADDR, d);
            if (d[6]) begin
                cnt = DATA_ZERO;
            end
            rdchk(CTRL_ADDR, exp_ctrl(d, 1'b1));
            rdchk(COUNT_ADDR, cnt);
        end
        wr(CTRL_ADDR, 32'h0000_0040);
        rdchk(CTRL_ADDR, DATA_ZERO);
        rdchk(COUNT_ADDR, DATA_ZERO);
        for (int s = 0; s < 8; s++) begin
            wr(CTRL_ADDR, 32'h0000_0040 | 32'(s));
            wr(CTRL_ADDR, 32'h0000_0080 | 32'(s));
            repeat (3 * OSC * div_of(s)) @(posedge clk_sys);
            apb(1'b0, COUNT_ADDR, DATA_ZERO);
            // 12*div+1 running edges: divide by one may catch a fourth tick
            check_range(rd, 32'h0000_0003, 32'(3 + (s == 0)));
        end
        do_reset();
        rdchk(CTRL_ADDR, DATA_ZERO);
        rdchk(COUNT_ADDR, DATA_ZERO);
        complete_run();
    end
endmodule : low_power_wakeup_timer_tb_top
